// >>> core/sdii_pkg.sv
// Shared constants and types of the serial converter front end.
// Assumes a 10 MHz system clock and an APB bus with 32-bit data.

package sdii_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Serial frame layout
  localparam int unsigned FRAME_BITS  = 24;
  localparam int unsigned CODE_BITS   = 18;
  localparam int unsigned COARSE_BITS = 16;
  localparam int unsigned FINE_BITS   = 2;
  localparam int unsigned CODE_MSB    = 19;
  localparam int unsigned CODE_LSB    = 2;
  localparam int unsigned CNT_W       = 5;
  localparam logic [CNT_W-1:0] LAST_BIT_IDX = 5'h17;

  // Power-up codes
  localparam logic [CODE_BITS-1:0] ZERO_CODE = 18'h00000;
  localparam logic [CODE_BITS-1:0] MID_CODE  = 18'h20000;

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned SYS_CLK_HZ     = 10_000_000;
  localparam int unsigned INTERP_RATE_HZ = 10_000;
  localparam int unsigned INTERP_DIV     = SYS_CLK_HZ / INTERP_RATE_HZ;
  localparam int unsigned INTERP_SLOTS   = 4;

  //////////////////////////////////////////////////////////////////////////////
  // APB register map, byte addresses
  localparam int unsigned APB_DATA_W = 32;
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] CODE_OFFSET   = 8'h08;
  localparam logic [7:0] LEVEL_OFFSET  = 8'h0C;

  // Field positions
  localparam int unsigned CTRL_LINK_EN_BIT   = 0;
  localparam int unsigned STAT_ABORT_BIT     = 0;
  localparam int unsigned STAT_LOADED_BIT    = 1;
  localparam int unsigned STAT_ACTIVE_BIT    = 2;
  localparam int unsigned STAT_CNT_LSB       = 8;
  localparam logic        CTRL_LINK_EN_RESET = 1'b1;

  // Frame receiver states
  typedef enum logic [1:0] {
    FR_IDLE,
    FR_SHIFT,
    FR_DONE
  } sdii_frame_e;

endpackage : sdii_pkg

// >>> core/sdii_sync.sv
// Two-flop synchroniser for levels from outside the clock domain.
// Assumes each bit is a slow level; no bus coherence between bits.

`timescale 1ns/1ns
`default_nettype none

module sdii_sync #(
  parameter int unsigned     WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sdii_sync_s;

  sdii_sync_s r_reg;
  sdii_sync_s r_next;

  always_comb begin
    r_next        = r_reg;
    r_next.stage1 = asyncIn;
    r_next.stage2 = r_reg.stage1;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= {RESET_VAL, RESET_VAL};
    end else begin
      r_reg <= r_next;
    end
  end

  assign syncOut = r_reg.stage2;

endmodule : sdii_sync

`default_nettype wire

// >>> core/sdii_interp.sv
// Interpolator: dithers a 16-bit coarse code with a 2-bit fine field.
// Assumes the code input comes from logic on the same clock.

`timescale 1ns/1ns
`default_nettype none

module sdii_interp
  import sdii_pkg::*;
#(
  parameter int unsigned DIV = INTERP_DIV
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  // Converter code
  input  wire logic [CODE_BITS-1:0]   code,
  // Converter drive
  output logic      [COARSE_BITS-1:0] level,
  output logic                        refresh
);

  localparam int unsigned DIV_W = $clog2(DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);

  typedef struct packed {
    logic [DIV_W-1:0]       divCnt;
    logic [FINE_BITS-1:0]   slot;
    logic [COARSE_BITS-1:0] level;
    logic                   refresh;
  } sdii_interp_s;

  sdii_interp_s r_reg;
  sdii_interp_s r_next;

  logic [COARSE_BITS-1:0] coarse;
  logic [FINE_BITS-1:0]   fine;

  assign coarse = code[CODE_BITS-1:FINE_BITS];
  assign fine   = code[FINE_BITS-1:0];

  always_comb begin
    r_next         = r_reg;
    r_next.refresh = 1'b0;
    if (r_reg.divCnt == DIV_LAST) begin
      r_next.divCnt  = '0;
      r_next.slot    = r_reg.slot + 1'b1;
      r_next.refresh = 1'b1;
    end else begin
      r_next.divCnt = r_reg.divCnt + 1'b1;
    end
    // Plus one in 'fine' of the four slots; full scale saturates
    if ((r_reg.slot < fine) && (coarse != '1)) begin
      r_next.level = coarse + 1'b1;
    end else begin
      r_next.level = coarse;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign level   = r_reg.level;
  assign refresh = r_reg.refresh;

endmodule : sdii_interp

`default_nettype wire

// >>> core/sdii_top.sv
// Serial converter front end: 24-bit frame receiver, converter register,
// power-up code, interpolator and an APB register slave.
// Assumes the serial pins are asynchronous and far slower than sys_clk.
//
// Register access over APB and the register addresses were decided locally.

`timescale 1ns/1ns
`default_nettype none

module sdii_top
  import sdii_pkg::*;
#(
  parameter logic        PWRUP_MIDSCALE = 1'b0,
  parameter int unsigned APB_ADDR_W     = 8,
  parameter int unsigned DIV            = INTERP_DIV
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,

  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [APB_ADDR_W-1:0]  paddr,
  input  wire logic [APB_DATA_W-1:0]  pwdata,
  output logic      [APB_DATA_W-1:0]  prdata,
  output logic                        pready,
  output logic                        pslverr,

  // Serial link pins
  input  wire logic                   frameSelN,
  input  wire logic                   serialClk,
  input  wire logic                   serialData,

  // Converter drive
  output logic      [CODE_BITS-1:0]   dacCode,
  output logic      [COARSE_BITS-1:0] dacLevel,
  output logic                        dacRefresh
);

  //////////////////////////////////////////////////////////////////////////////
  // Constants

  // Midscale: only the top code bit set
  localparam logic [CODE_BITS-1:0] PWRUP_CODE =
    PWRUP_MIDSCALE ? MID_CODE : ZERO_CODE;

  //////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    sdii_frame_e           state;
    logic [FRAME_BITS-1:0] shift;
    logic [CNT_W-1:0]      bitCnt;
    logic [CODE_BITS-1:0]  code;
    logic                  loaded;
    logic                  abortSeen;
    logic                  linkEnable;
    logic                  sclkPrev;
    logic                  selPrev;
    logic                  pready;
    logic                  pslverr;
    logic [APB_DATA_W-1:0] prdata;
  } sdii_top_s;

  sdii_top_s r_reg;
  sdii_top_s r_next;

  logic                   selS;
  logic                   sclkS;
  logic                   dataS;
  logic [COARSE_BITS-1:0] levelQ;
  logic                   refreshQ;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Select idles high, so its chain resets high to avoid a false start
  sdii_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b1)
  ) u_sel_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .asyncIn (frameSelN),
    .syncOut (selS)
  );

  // Clock and data share one chain, keeping their relative delay equal
  sdii_sync #(
    .WIDTH     (2),
    .RESET_VAL (2'h0)
  ) u_bit_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .asyncIn ({serialClk, serialData}),
    .syncOut ({sclkS, dataS})
  );

  //////////////////////////////////////////////////////////////////////////////
  // Edge detection on the synchronised pins

  logic sclkFall;
  logic selRise;
  logic selFall;

  assign sclkFall = r_reg.sclkPrev & ~sclkS;
  assign selRise  = ~r_reg.selPrev & selS;
  assign selFall  = r_reg.selPrev & ~selS;

  //////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic                  apbSetup;
  logic                  apbAccess;
  logic [APB_DATA_W-1:0] rdValue;
  logic                  addrHit;
  logic [APB_DATA_W-1:0] statusWord;

  assign apbSetup  = psel & ~penable;
  assign apbAccess = psel & penable & r_reg.pready;

  always_comb begin
    statusWord                              = '0;
    statusWord[STAT_ABORT_BIT]              = r_reg.abortSeen;
    statusWord[STAT_LOADED_BIT]             = r_reg.loaded;
    statusWord[STAT_ACTIVE_BIT]             = (r_reg.state == FR_SHIFT);
    statusWord[STAT_CNT_LSB +: CNT_W]       = r_reg.bitCnt;
  end

  always_comb begin
    rdValue = '0;
    addrHit = 1'b1;
    case (paddr[7:0])
      CTRL_OFFSET: begin
        rdValue[CTRL_LINK_EN_BIT] = r_reg.linkEnable;
      end
      STATUS_OFFSET: begin
        rdValue = statusWord;
      end
      CODE_OFFSET: begin
        rdValue[CODE_BITS-1:0] = r_reg.code;
      end
      LEVEL_OFFSET: begin
        rdValue[COARSE_BITS-1:0] = levelQ;
      end
      default: begin
        addrHit = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    r_next          = r_reg;
    r_next.sclkPrev = sclkS;
    r_next.selPrev  = selS;

    // No wait state: answer prepared in setup, presented in access
    if (apbSetup) begin
      r_next.pready  = 1'b1;
      r_next.pslverr = ~addrHit;
      r_next.prdata  = pwrite ? '0 : rdValue;
    end else begin
      r_next.pready  = 1'b0;
      r_next.pslverr = 1'b0;
      r_next.prdata  = '0;
    end

    // Register writes; abort set below wins over a clear here
    if (apbAccess && pwrite && addrHit) begin
      case (paddr[7:0])
        CTRL_OFFSET: begin
          r_next.linkEnable = pwdata[CTRL_LINK_EN_BIT];
        end
        STATUS_OFFSET: begin
          if (pwdata[STAT_ABORT_BIT]) begin
            r_next.abortSeen = 1'b0;
          end
        end
        default: begin
          r_next.linkEnable = r_reg.linkEnable;
        end
      endcase
    end

    // Frame receiver
    case (r_reg.state)
      FR_IDLE: begin
        // Only a falling select edge opens a frame
        if (selFall && r_reg.linkEnable) begin
          r_next.state  = FR_SHIFT;
          r_next.shift  = '0;
          r_next.bitCnt = '0;
        end
      end
      FR_SHIFT: begin
        if (selRise || !r_reg.linkEnable) begin
          // Early rise: drop partial bits, code and mode untouched
          r_next.state  = FR_IDLE;
          r_next.shift  = '0;
          r_next.bitCnt = '0;
          if (selRise) begin
            r_next.abortSeen = 1'b1;
          end
        end else if (sclkFall) begin
          // Most significant bit arrives first
          r_next.shift = {r_reg.shift[FRAME_BITS-2:0], dataS};
          if (r_reg.bitCnt == LAST_BIT_IDX) begin
            // Top two and reserved pair dropped, trailing two dropped
            r_next.code   = r_next.shift[CODE_MSB:CODE_LSB];
            r_next.loaded = 1'b1;
            r_next.state  = FR_DONE;
          end else begin
            r_next.bitCnt = r_reg.bitCnt + 1'b1;
          end
        end
      end
      FR_DONE: begin
        // Extra clock edges ignored until select is raised
        if (selS) begin
          r_next.state  = FR_IDLE;
          r_next.bitCnt = '0;
        end
      end
      default: begin
        r_next.state = FR_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg            <= '0;
      r_reg.state      <= FR_IDLE;
      r_reg.code       <= PWRUP_CODE;
      r_reg.linkEnable <= CTRL_LINK_EN_RESET;
      r_reg.selPrev    <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interpolator

  sdii_interp #(
    .DIV (DIV)
  ) u_interp (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .code    (r_reg.code),
    .level   (levelQ),
    .refresh (refreshQ)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata     = r_reg.prdata;
  assign pready     = r_reg.pready;
  assign pslverr    = r_reg.pslverr;
  assign dacCode    = r_reg.code;
  assign dacLevel   = levelQ;
  assign dacRefresh = refreshQ;

endmodule : sdii_top

`default_nettype wire

// >>> sim/sdii_assertions.sv
// Port checker of the serial converter front end.
// Assumes it is bound into sdii_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module sdii_assertions
  import sdii_pkg::*;
#(
  parameter logic        PWRUP_MIDSCALE = 1'b0,
  parameter int unsigned DIV            = INTERP_DIV
) (
  // Clock and reset
  input wire logic                   sys_clk,
  input wire logic                   rst_n,
  // APB
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic [APB_DATA_W-1:0]  prdata,
  // Link and converter
  input wire logic                   frameSelN,
  input wire logic [CODE_BITS-1:0]   dacCode,
  input wire logic [COARSE_BITS-1:0] dacLevel,
  input wire logic                   dacRefresh
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  // Gap counter; the first slot after reset is not judged
  logic [15:0] gapCnt;
  logic        seenRef;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gapCnt  <= 16'h0000;
      seenRef <= 1'b0;
    end else begin
      gapCnt  <= dacRefresh ? 16'h0000 : gapCnt + 16'h0001;
      seenRef <= seenRef | dacRefresh;
    end
  end
  property p_rate;
    dacRefresh && seenRef |-> gapCnt == 16'(DIV - 1);
  endproperty
  a_rate: assert property (p_rate) else $error("refresh spacing");
  property p_lvl;
    $past(rst_n) |-> dacLevel == $past(dacCode[17:2])
      || dacLevel == $past(dacCode[17:2]) + 16'h0001;
  endproperty
  a_lvl: assert property (p_lvl) else $error("level off code");
  property p_fine0;
    $past(rst_n) && $stable(dacCode) && dacCode[1:0] == 2'b00
      |-> dacLevel == dacCode[17:2];
  endproperty
  a_fine0: assert property (p_fine0) else $error("level switching");
  property p_load;
    $changed(dacCode) |-> !$past(frameSelN);
  endproperty
  a_load: assert property (p_load) else $error("code load w/o frame");
  property p_pwr;
    $rose(rst_n) |-> dacCode == (PWRUP_MIDSCALE ? MID_CODE : ZERO_CODE);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power-up code");
  property p_rdy;
    psel && !penable |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_one;
    pready |=> !pready;
  endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_err;
    pslverr |-> pready && prdata == 32'h00000000;
  endproperty
  a_err: assert property (p_err) else $error("error w/o ready");
endmodule : sdii_assertions
`default_nettype wire

// >>> sim/sdii_host.sv
// Host serial port model driving the three-wire link.
// Assumes frame() is called by one caller at a time.
`timescale 1ns/1ns
`default_nettype none
module sdii_host (
  // Link pins
  output logic selN,
  output logic sclk,
  output logic sdo
);
  initial begin
    selN = 1'b1;
    sclk = 1'b0;
    sdo  = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  // Sends n falls of w; n below 24 aborts the frame
  task automatic frame(input logic [23:0] w, input int n);
    #37 selN = 1'b0; // Off phase to sys_clk
    #400;
    for (int i = 0; i < n; i++) begin
      if (i > 0 && i % 8 == 0) #400; // Byte gap
      sdo  = w[(47 - i) % 24];
      sclk = 1'b1; // Idles low, data set on rise
      #400 sclk = 1'b0;
      #400;
    end
    #1200 sdo = ~sdo; // Released line shows no stale bit
    selN = 1'b1;
    #800;
  endtask : frame
endmodule : sdii_host
`default_nettype wire

// >>> sim/sdii_tb.sv
// Self-checking bench of the serial converter front end.
// Assumes the host model and the checker beside it.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb
  import sdii_pkg::*;
;
  localparam int unsigned TB_DIV = 4; // Short slots keep the run brief
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdData;
  logic        pready, pslverr, rdErr, dacRefresh;
  logic        frameSelN, serialClk, serialData;
  logic [17:0] dacCode, keep, midCode;
  logic [15:0] dacLevel;
  logic [23:0] word;
  int          n_errors = 0, comparisons = 0, seed = 32'hA153, hi, nRef;
  int          cut[3] = '{1, 12, 23};
  always #50 sys_clk = ~sys_clk;
  sdii_host host_u (.selN(frameSelN), .sclk(serialClk), .sdo(serialData));
  sdii_top #(.DIV(TB_DIV)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frameSelN(frameSelN),
    .serialClk(serialClk), .serialData(serialData), .dacCode(dacCode),
    .dacLevel(dacLevel), .dacRefresh(dacRefresh));
  // Midscale variant; the bench compares only its power-up code
  sdii_top #(.PWRUP_MIDSCALE(1'b1), .DIV(TB_DIV)) dut_mid_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(1'b0), .penable(1'b0),
    .pwrite(1'b0), .paddr(8'h00), .pwdata(32'h00000000), .prdata(),
    .pready(), .pslverr(), .frameSelN(1'b1), .serialClk(1'b0),
    .serialData(1'b0), .dacCode(midCode), .dacLevel(), .dacRefresh());
  ////////////////////////////////////////////////////////////
  function automatic logic [17:0] code_of(input logic [23:0] w);
    return w[19:2];
  endfunction : code_of
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) n_errors++;
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    #3_000_000; // Several times the planned run
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    `CHK("pwrup", ZERO_CODE, dacCode)
    `CHK("pwrup mid", 18'h20000, midCode)
    apb(1'b0, CTRL_OFFSET, 32'h0);
    `CHK("ctrl", 32'h1, rdData)
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 1'b1, rdErr)
    $display("reset test done");
    for (int t = 0; t < 6; t++) begin
      word = $random(seed);
      word[21:20] = 2'b00;
      host_u.frame(word, 24 + t % 3); // Late edges ignored
      `CHK("code", code_of(word), dacCode)
      apb(1'b0, CODE_OFFSET, 32'h0);
      `CHK("code reg", {14'h0, code_of(word)}, rdData)
    end
    $display("frame test done");
    foreach (cut[i]) begin
      keep = dacCode;
      word = $random(seed);
      host_u.frame(word, cut[i]);
      `CHK("abort", keep, dacCode)
      apb(1'b0, STATUS_OFFSET, 32'h0);
      `CHK("flag", 2'h3, rdData[1:0])
      apb(1'b1, STATUS_OFFSET, 32'h1);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      `CHK("clear", 1'b0, rdData[0])
      word[21:20] = 2'b00;
      host_u.frame(word, 24);
      `CHK("after abort", code_of(word), dacCode)
    end
    $display("abort test done");
    apb(1'b1, CTRL_OFFSET, 32'h0);
    keep = dacCode;
    host_u.frame(~word & 24'hCFFFFF, 24);
    `CHK("link off", keep, dacCode)
    apb(1'b1, CTRL_OFFSET, 32'h1);
    for (int f = 0; f < 4; f++) begin
      word = {4'h0, 18'h00FFC + 18'(f), 2'h0};
      host_u.frame(word, 24);
      hi = 0;
      nRef = 0;
      repeat (4 * TB_DIV) begin
        @(negedge sys_clk);
        hi += (dacLevel === 16'h0400) ? 1 : 0;
        nRef += (dacRefresh === 1'b1) ? 1 : 0;
      end
      `CHK("duty", f * TB_DIV, hi)
      `CHK("refresh", 4, nRef)
    end
    $display("interpolator test done");
    complete_run();
  end
endmodule : tb
bind sdii_top sdii_assertions #(.PWRUP_MIDSCALE(PWRUP_MIDSCALE), .DIV(DIV)) chk_u (
  .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .prdata(prdata), .frameSelN(frameSelN),
  .dacCode(dacCode), .dacLevel(dacLevel), .dacRefresh(dacRefresh));
`default_nettype wire
